/* File: i2c_ctrl_model.sv */
// Behavioural I2C bus controller that writes into the emulated target
`timescale 1ns/1ps
module i2c_ctrl_model (
  output logic scl,
  output logic sda,
  input wire logic sdaLine
);
  // Quarter bit; keeps SCL low well beyond the target's sync and edge delay
  localparam int Q = 100;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic startCond();
    #Q sda = 1'b1;
    #Q scl = 1'b1;
    #Q sda = 1'b0;
    #Q scl = 1'b0;
  endtask
  task automatic stopCond();
    #Q sda = 1'b0;
    #Q scl = 1'b1;
    #Q sda = 1'b1;
    #Q;
  endtask
  // Data moves only mid-low, away from SCL edges, so no false condition is seen
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #Q sda = b[i];
      #Q scl = 1'b1;
      #(2*Q) scl = 1'b0;
    end
    #Q sda = 1'b1;
    #Q scl = 1'b1;
    #Q ack = ~sdaLine;
    #Q scl = 1'b0;
  endtask
endmodule

/* File: i2c_target_event_readout.sv */
// Emulated I2C target: write capture into events and host readout of those events
//
// How it works
// - Reads serve only command or data events
// - Read returns min of request and remaining
// - Drained pulse once last event byte read
// - Largest event is max of both depths
// - Each event bounded by its own depth
// - Start latches configuration and joins bus
// - On bus, configured address is acknowledged for writes only
// - After start, events are produced
// - Stop leaves bus and drops pending event
// - Seven bit address, bit zero is direction
// - Zero command depth disables command capture
// - Command event on fill or write end
// - Data event on fill or end; 128 default
`timescale 1ns/1ps
module i2c_target_event_readout
  import i2c_target_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic sclOut,
  output logic sclOe,
  input wire logic [ADDR_W-1:0] cfgAddress,
  input wire logic [DEPTH_W-1:0] cfgCmdDepth,
  input wire logic [DEPTH_W-1:0] cfgDataDepth,
  input wire logic startReq,
  input wire logic stopReq,
  input wire logic readReq,
  input wire logic [DEPTH_W-1:0] readRequestCount,
  output logic onBus,
  output logic commandCaptureEvent,
  output logic dataAvailableEvent,
  output logic readValid,
  output logic [BYTE_W-1:0] readData,
  output logic readDone,
  output logic [DEPTH_W-1:0] readCount,
  output logic eventDrained,
  output logic [DEPTH_W-1:0] maxEventBytes
);

  typedef enum logic [1:0] {
    ST_OFF,
    ST_CAPTURE,
    ST_PENDING,
    ST_READ
  } state_t;

  state_t state_r;
  logic [ADDR_W-1:0] addrAct_r;
  logic [DEPTH_W-1:0] cmdDepthAct_r, dataDepthAct_r;
  logic cmdPhase_r;
  logic [BYTE_W-1:0] mem [0:BUF_WORDS-1];
  logic [DEPTH_W-1:0] fill_r, rdPtr_r, left_r;
  logic [DEPTH_W-1:0] curDepth, fillNxt, remain, grant;
  logic accept, addrHit, byteValid, busEnd, rxSdaOe;
  logic [BYTE_W-1:0] byteData;

  i2c_target_rx rx (
    .core_clk(core_clk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .enable(onBus),
    .accept(accept),
    .address(addrAct_r),
    .sdaOe(rxSdaOe),
    .addrHit(addrHit),
    .byteValid(byteValid),
    .byteData(byteData),
    .busEnd(busEnd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Only one event can be outstanding; bytes that arrive meanwhile are
  // refused with a NACK rather than queued, which keeps one buffer enough
  assign curDepth = cmdPhase_r ? cmdDepthAct_r : dataDepthAct_r;
  assign accept = (state_r == ST_CAPTURE) && (curDepth != DEPTH_ZERO);
  assign fillNxt = fill_r + DEPTH_ONE;
  assign remain = fill_r - rdPtr_r;
  assign grant = minOf(readRequestCount, remain);

  // Pins: the target only ever pulls SDA low, and never stretches SCL
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
      sclOe <= 1'b0;
    end else begin
      sdaOe <= rxSdaOe & onBus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration commit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addrAct_r <= ADDR_RST;
      cmdDepthAct_r <= CMD_DEPTH_RST;
      dataDepthAct_r <= DATA_DEPTH_RST;
      maxEventBytes <= maxOf(CMD_DEPTH_RST, DATA_DEPTH_RST);
    end else begin
      if (startReq && !stopReq) begin
        addrAct_r <= cfgAddress;
        cmdDepthAct_r <= cfgCmdDepth;
        dataDepthAct_r <= cfgDataDepth;
      end
      maxEventBytes <= maxOf(cmdDepthAct_r, dataDepthAct_r);
    end
  end

  // Capture buffer; written only while accepting, so no reset needed
  always_ff @(posedge core_clk) begin
    if (byteValid && state_r == ST_CAPTURE) begin
      mem[fill_r] <= byteData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event sequencing and readout
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_OFF;
      onBus <= 1'b0;
      cmdPhase_r <= 1'b0;
      fill_r <= '0;
      rdPtr_r <= '0;
      left_r <= '0;
      commandCaptureEvent <= 1'b0;
      dataAvailableEvent <= 1'b0;
      readValid <= 1'b0;
      readData <= '0;
      readDone <= 1'b0;
      readCount <= '0;
      eventDrained <= 1'b0;
    end else begin
      readValid <= 1'b0;
      readDone <= 1'b0;
      eventDrained <= 1'b0;
      if (stopReq) begin
        // Stop wins over a start in the same cycle
        state_r <= ST_OFF;
        onBus <= 1'b0;
        commandCaptureEvent <= 1'b0;
        dataAvailableEvent <= 1'b0;
        fill_r <= '0;
        rdPtr_r <= '0;
      end else if (startReq) begin
        state_r <= ST_CAPTURE;
        onBus <= 1'b1;
        cmdPhase_r <= (cfgCmdDepth != DEPTH_ZERO);
        commandCaptureEvent <= 1'b0;
        dataAvailableEvent <= 1'b0;
        fill_r <= '0;
        rdPtr_r <= '0;
      end else begin
        // Each new write, and each write end, restarts with the command part unless its depth is zero
        if (addrHit || busEnd) begin
          cmdPhase_r <= (cmdDepthAct_r != DEPTH_ZERO);
        end
        case (state_r)
          ST_CAPTURE: begin
            if (byteValid) begin
              fill_r <= fillNxt;
              if (fillNxt == curDepth) begin
                // Buffer full: raise the event for the current part
                state_r <= ST_PENDING;
                commandCaptureEvent <= cmdPhase_r;
                dataAvailableEvent <= !cmdPhase_r;
                if (!busEnd && !addrHit) begin
                  cmdPhase_r <= 1'b0;
                end
              end
            end else if (busEnd && fill_r != DEPTH_ZERO) begin
              state_r <= ST_PENDING;
              commandCaptureEvent <= cmdPhase_r;
              dataAvailableEvent <= !cmdPhase_r;
            end
            if (readReq) begin
              // No event to serve: answer with an empty read
              readDone <= 1'b1;
              readCount <= '0;
            end
          end
          ST_PENDING: begin
            if (readReq) begin
              readCount <= grant;
              left_r <= grant;
              if (grant == DEPTH_ZERO) begin
                readDone <= 1'b1;
              end else begin
                state_r <= ST_READ;
              end
            end
          end
          ST_READ: begin
            readValid <= 1'b1;
            readData <= mem[rdPtr_r];
            rdPtr_r <= rdPtr_r + DEPTH_ONE;
            left_r <= left_r - DEPTH_ONE;
            if (left_r == DEPTH_ONE) begin
              readDone <= 1'b1;
              if (rdPtr_r + DEPTH_ONE == fill_r) begin
                // Event handled only when every byte has gone out
                eventDrained <= 1'b1;
                commandCaptureEvent <= 1'b0;
                dataAvailableEvent <= 1'b0;
                fill_r <= '0;
                rdPtr_r <= '0;
                state_r <= ST_CAPTURE;
              end else begin
                state_r <= ST_PENDING;
              end
            end
          end
          default: begin
            if (readReq) begin
              readDone <= 1'b1;
              readCount <= '0;
            end
          end
        endcase
      end
    end
  end

endmodule

/* File: i2c_target_event_readout_chk.sv */
// Port checks for the emulated I2C target and its event readout
`timescale 1ns/1ps
module i2c_target_event_readout_chk
  import i2c_target_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sdaOe,
  input wire logic [DEPTH_W-1:0] cfgCmdDepth,
  input wire logic [DEPTH_W-1:0] cfgDataDepth,
  input wire logic startReq,
  input wire logic stopReq,
  input wire logic onBus,
  input wire logic commandCaptureEvent,
  input wire logic dataAvailableEvent,
  input wire logic readValid,
  input wire logic readDone,
  input wire logic [DEPTH_W-1:0] readCount,
  input wire logic eventDrained,
  input wire logic [DEPTH_W-1:0] maxEventBytes
);
  logic [DEPTH_W-1:0] maxSnap_r;
  logic [DEPTH_W-1:0] validCnt_r;
  logic anyEvent;
  assign anyEvent = commandCaptureEvent || dataAvailableEvent;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Depths snapshot at start, so a later config change cannot hide a stale value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      maxSnap_r <= DATA_DEPTH_RST;
    end else if (startReq && !stopReq) begin
      maxSnap_r <= (cfgCmdDepth > cfgDataDepth) ? cfgCmdDepth : cfgDataDepth;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      validCnt_r <= DEPTH_ZERO;
    end else if (readDone || stopReq) begin
      validCnt_r <= DEPTH_ZERO;
    end else if (readValid) begin
      validCnt_r <= validCnt_r + DEPTH_ONE;
    end
  end
  ////////////////////////////////////////
  a_data_needs_event: assert property (readValid |-> $past(anyEvent))
    else $error("byte read without event");
  a_grant_count: assert property (readDone |-> validCnt_r + readValid == readCount)
    else $error("byte count differs from grant");
  a_drain_with_done: assert property (eventDrained |-> readDone && !anyEvent)
    else $error("drain pulse misplaced");
  a_max_bytes: assert property (startReq && !stopReq |-> ##2 maxEventBytes == maxSnap_r)
    else $error("max event bytes wrong");
  a_count_bound: assert property (readDone |-> readCount <= maxEventBytes)
    else $error("grant above event size");
  a_start_joins: assert property (startReq && !stopReq |=> onBus && !anyEvent)
    else $error("start did not join");
  a_stop_leaves: assert property (stopReq |=> !onBus && !anyEvent)
    else $error("stop did not leave");
  a_event_on_bus: assert property (anyEvent |-> onBus)
    else $error("event while off bus");
  a_off_no_ack: assert property (!onBus [*3] |-> !sdaOe)
    else $error("acknowledge while off bus");
  c_cmd_event: cover property ($rose(commandCaptureEvent));
  c_data_event: cover property ($rose(dataAvailableEvent));
  c_drained: cover property (eventDrained);
endmodule
bind i2c_target_event_readout i2c_target_event_readout_chk i2c_target_event_readout_chk_i (.*);

/* File: i2c_target_pkg.sv */
// Shared constants, types and helpers for the emulated I2C target
package i2c_target_pkg;

  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int DEPTH_W = 8;
  localparam int BUF_WORDS = 256;
  localparam int BIT_CNT_W = 4;

  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [DEPTH_W-1:0] CMD_DEPTH_RST = 8'h00;
  localparam logic [DEPTH_W-1:0] DATA_DEPTH_RST = 8'h80;
  localparam logic [DEPTH_W-1:0] DEPTH_ZERO = 8'h00;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 8'h01;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;

  typedef enum logic {
    KIND_DATA,
    KIND_CMD
  } event_kind_t;

  function automatic logic [DEPTH_W-1:0] minOf(input logic [DEPTH_W-1:0] a,
                                               input logic [DEPTH_W-1:0] b);
    minOf = (a < b) ? a : b;
  endfunction

  function automatic logic [DEPTH_W-1:0] maxOf(input logic [DEPTH_W-1:0] a,
                                               input logic [DEPTH_W-1:0] b);
    maxOf = (a > b) ? a : b;
  endfunction

endpackage

/* File: i2c_target_rx.sv */
// Bit level I2C target receiver: conditions, address match, byte capture, acknowledge
`timescale 1ns/1ps
module i2c_target_rx
  import i2c_target_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic enable,
  input wire logic accept,
  input wire logic [ADDR_W-1:0] address,
  output logic sdaOe,
  output logic addrHit,
  output logic byteValid,
  output logic [BYTE_W-1:0] byteData,
  output logic busEnd
);

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_ADDR,
    RX_DATA,
    RX_ACK,
    RX_SKIP
  } rx_state_t;

  logic sclMeta_r, sclSync_r, sclPrev_r;
  logic sdaMeta_r, sdaSync_r, sdaPrev_r;
  rx_state_t busState_r;
  logic [BIT_CNT_W-1:0] bitCnt_r;
  logic [BYTE_W-1:0] shift_r;
  logic ackNext_r;
  logic selected_r;
  logic sclRise, sclFall, startCond, stopCond, addrMatch;
  logic [BYTE_W-1:0] fullByte;

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from another party, so both lines pass two flops first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclMeta_r <= 1'b1;
      sclSync_r <= 1'b1;
      sclPrev_r <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclMeta_r <= sclIn;
      sclSync_r <= sclMeta_r;
      sclPrev_r <= sclSync_r;
      sdaMeta_r <= sdaIn;
      sdaSync_r <= sdaMeta_r;
      sdaPrev_r <= sdaSync_r;
    end
  end

  assign sclRise = sclSync_r & ~sclPrev_r;
  assign sclFall = ~sclSync_r & sclPrev_r;
  assign startCond = sclSync_r & sclPrev_r & sdaPrev_r & ~sdaSync_r;
  assign stopCond = sclSync_r & sclPrev_r & ~sdaPrev_r & sdaSync_r;
  assign fullByte = {shift_r[BYTE_W-2:0], sdaSync_r};
  // Only write direction is served; a read header is not acknowledged
  assign addrMatch = enable && (fullByte[BYTE_W-1:1] == address) && !fullByte[0];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busState_r <= RX_IDLE;
      bitCnt_r <= '0;
      shift_r <= '0;
      ackNext_r <= 1'b0;
      selected_r <= 1'b0;
      sdaOe <= 1'b0;
      addrHit <= 1'b0;
      byteValid <= 1'b0;
      byteData <= '0;
      busEnd <= 1'b0;
    end else begin
      addrHit <= 1'b0;
      byteValid <= 1'b0;
      busEnd <= 1'b0;
      if (!enable) begin
        // Off the bus: lines released, nothing acknowledged
        busState_r <= RX_IDLE;
        sdaOe <= 1'b0;
        selected_r <= 1'b0;
      end else if (startCond || stopCond) begin
        // Repeated start or stop ends a write this target was part of
        busEnd <= selected_r;
        selected_r <= 1'b0;
        sdaOe <= 1'b0;
        bitCnt_r <= '0;
        busState_r <= startCond ? RX_ADDR : RX_IDLE;
      end else begin
        case (busState_r)
          RX_ADDR, RX_DATA: begin
            if (sclRise) begin
              shift_r <= fullByte;
              bitCnt_r <= bitCnt_r + 4'h1;
              if (bitCnt_r == LAST_BIT) begin
                if (busState_r == RX_ADDR) begin
                  ackNext_r <= addrMatch;
                  addrHit <= addrMatch;
                  selected_r <= addrMatch;
                end else begin
                  ackNext_r <= accept;
                  byteValid <= accept;
                  byteData <= fullByte;
                end
              end
            end else if (sclFall && bitCnt_r == BITS_PER_BYTE) begin
              sdaOe <= ackNext_r;
              bitCnt_r <= '0;
              busState_r <= RX_ACK;
            end
          end
          RX_ACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              busState_r <= ackNext_r ? RX_DATA : RX_SKIP;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule

/* File: testbench.sv */
// Self-checking bench for the emulated I2C target event readout
`timescale 1ns/1ps
module testbench;
  import i2c_target_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, startReq = 1'b0, stopReq = 1'b0, readReq = 1'b0;
  logic [ADDR_W-1:0] cfgAddress = 7'h00;
  logic [DEPTH_W-1:0] cfgCmdDepth = 8'h00, cfgDataDepth = 8'h80, readRequestCount = 8'h00;
  logic sclDrv, sdaDrv, sdaOut, sdaOe, sclOut, sclOe, onBus, readValid, readDone;
  logic commandCaptureEvent, dataAvailableEvent, eventDrained;
  logic [7:0] readData, readCount, maxEventBytes, left;
  logic [7:0] txd [0:15];
  int nErrors = 0, cmpCount = 0, pos = 0, cycles = 0;
  // Pull-ups: a line is low only while some party pulls it
  wire sclIn = sclDrv & ~(sclOe & ~sclOut);
  wire sdaIn = sdaDrv & ~(sdaOe & ~sdaOut);
  i2c_target_event_readout i2c_target_event_readout_i (.*);
  i2c_ctrl_model i2c_ctrl_model_i (.scl(sclDrv), .sda(sdaDrv), .sdaLine(sdaIn));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic endSim();
    if (nErrors == 0 && cmpCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [7:0] big(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction
  task automatic ctl(input logic go);
    @(posedge core_clk);
    startReq <= go;
    stopReq <= ~go;
    @(posedge core_clk);
    startReq <= 1'b0;
    stopReq <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // h: header acknowledged, k: data bytes expected to be stored
  task automatic busWrite(input logic [7:0] hdr, input int n, input logic h, input int k);
    logic a;
    i2c_ctrl_model_i.startCond();
    i2c_ctrl_model_i.sendByte(hdr, a);
    check("hdrAck", a, h);
    for (int i = 0; i < n; i++) begin
      txd[i] = 8'($urandom);
      i2c_ctrl_model_i.sendByte(txd[i], a);
      check("byteAck", a, h && i < k);
    end
    i2c_ctrl_model_i.stopCond();
    pos = 0;
    left = 8'(k);
    repeat (20) @(posedge core_clk);
    #1;
  endtask
  task automatic readOnce(input logic [7:0] req);
    logic [7:0] g;
    logic [7:0] nb;
    int n;
    g = (req < left) ? req : left;
    nb = 8'h00;
    n = 0;
    @(posedge core_clk);
    readReq <= 1'b1;
    readRequestCount <= req;
    @(posedge core_clk);
    readReq <= 1'b0;
    // Grant and an empty answer stand right after the taking edge; a one byte
    // answer ends one edge later, so sampling starts here
    #1;
    check("readCount", readCount, g);
    while (readDone !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      if (readValid === 1'b1) begin
        check("readData", readData, txd[pos]);
        pos++;
        nb++;
      end
      n++;
    end
    check("readDone", readDone, 1'b1);
    check("nBytes", nb, g);
    check("drained", eventDrained, left != 0 && g == left);
    left = left - g;
  endtask
  ////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      nErrors++;
      endSim();
    end
  end
  initial begin
    logic [6:0] adr;
    logic [7:0] d;
    void'($urandom(21));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check("maxBytes", maxEventBytes, 8'h80);
    left = 8'h00;
    readOnce(8'h04);
    busWrite(8'h00, 1, 1'b0, 0);
    adr = 7'h08 + 7'($urandom % 100);
    d = 8'h03 + 8'($urandom % 5);
    @(posedge core_clk);
    cfgAddress <= adr;
    cfgCmdDepth <= 8'h02;
    cfgDataDepth <= d;
    ctl(1'b1);
    check("onBus", onBus, 1'b1);
    check("maxBytes", maxEventBytes, big(8'h02, d));
    busWrite({adr, 1'b0}, 3, 1'b1, 2);
    check("command_capture_event", commandCaptureEvent, 1'b1);
    readOnce(8'h01);
    readOnce(8'h05);
    busWrite({adr ^ 7'h01, 1'b0}, 1, 1'b0, 0);
    busWrite({adr, 1'b1}, 0, 1'b0, 0);
    busWrite({adr, 1'b0}, 1, 1'b1, 1);
    check("command_capture_event", commandCaptureEvent, 1'b1);
    readOnce(8'h00);
    readOnce(8'h03);
    @(posedge core_clk);
    cfgCmdDepth <= 8'h00;
    ctl(1'b1);
    check("maxBytes", maxEventBytes, d);
    busWrite({adr, 1'b0}, d + 1, 1'b1, d);
    check("dataEvent", dataAvailableEvent, 1'b1);
    check("command_capture_event", commandCaptureEvent, 1'b0);
    while (left > 0 && pos < 16) begin
      readOnce(8'h01 + 8'($urandom % 4));
    end
    busWrite({adr, 1'b0}, 2, 1'b1, 2);
    check("dataEvent", dataAvailableEvent, 1'b1);
    ctl(1'b0);
    check("onBus", onBus, 1'b0);
    check("dataEvent", dataAvailableEvent, 1'b0);
    busWrite({adr, 1'b0}, 1, 1'b0, 0);
    check("sdaOe", sdaOe, 1'b0);
    check("sclOe", sclOe, 1'b0);
    check("sclOut", sclOut, 1'b0);
    check("sdaOut", sdaOut, 1'b0);
    endSim();
  end
endmodule
